// *** src/secondary_input_pin_select.sv ***
// Secondary core input pin-select: selector registers, pin sync and routing.
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module secondary_input_pin_select
   import pin_select_pkg::*;
#(
   parameter int NUM_PINS = PIN_COUNT
)
(
   // Clock and reset.
   input  wire  logic                    mclk,
   input  wire  logic                    rst,
   // Register port.
   input  wire  logic [ADDR_W-1:0]       reg_addr,
   input  wire  logic [REG_W-1:0]        reg_wdata,
   input  wire  logic                    reg_wr,
   input  wire  logic                    reg_rd,
   output var   logic [REG_W-1:0]        reg_rdata,
   // Remappable sources.
   input  wire  logic [NUM_PINS-1:0]     remappable_source,
   input  wire  logic [NUM_INTERNAL-1:0] internal_src,
   input  wire  logic [NUM_DAC-1:0]      dac_pwm_req,
   input  wire  logic [NUM_VIRT-1:0]     main_virtual_outputs,
   input  wire  logic [NUM_VIRT-1:0]     virtual_remap_pin,
   // Routed results.
   output var   logic [NUM_FIELDS-1:0]   periph_in,
   output var   logic                    converter_trigger_31,
   output var   logic [NUM_VIRT-1:0]     to_main_virtual,
   output var   logic                    remap_write_lock
);

   ////////////////////////////////////////////////////////////////////////////////
   // Parameter check: pin sources occupy a fixed code range.
   generate
      if (NUM_PINS < 1 || NUM_PINS > PIN_COUNT) begin : g_bad_pins
         $error("pin count outside the pin source range");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // All state of the block.
   typedef struct packed {
      logic [NUM_PINS-1:0]                pin_s1;
      logic [NUM_PINS-1:0]                pin_s2;
      logic [NUM_PINS-1:0]                pin_s3;
      logic [NUM_PINS-1:0]                pin_ok;
      logic [NUM_VIRT-1:0]                mv_s1;
      logic [NUM_VIRT-1:0]                mv_s2;
      logic [NUM_VIRT-1:0]                mv_s3;
      logic [NUM_VIRT-1:0]                mv_ok;
      logic                               lock;
      logic [NUM_SEL_REGS-1:0][REG_W-1:0] sel;
      logic [REG_W-1:0]                   rdata;
      logic [NUM_FIELDS-1:0]              periph;
      logic                               trig;
      logic [NUM_VIRT-1:0]                to_main;
   } state_s;

   state_s st;
   state_s next_st;

   sel_mux_if mx ();

   logic [ADDR_W-1:0] sel_idx;
   logic              sel_hit;

   ////////////////////////////////////////////////////////////////////////////////
   // Byte mask of the fields that really exist in one selector register.
   function automatic logic [REG_W-1:0] field_mask(input int unsigned i);
      logic [REG_W-1:0] m;
      m = {{SEL_W{HI_USED[i]}}, {SEL_W{LO_USED[i]}}};
      return m;
   endfunction : field_mask

   ////////////////////////////////////////////////////////////////////////////////
   // Address decode of the selector window.
   always_comb begin
      sel_idx = reg_addr - SEL_BASE_OFFSET;
      sel_hit = (reg_addr >= SEL_BASE_OFFSET) && (reg_addr <= SEL_LAST_OFFSET);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Source vector. Code 0 is ground and every reserved code reads as zero,
   // so a stray selector value parks the input low instead of floating.
   always_comb begin
      mx.src_vec = '0;
      mx.src_vec[SRC_INTERNAL_FIRST +: NUM_INTERNAL] = internal_src;
      mx.src_vec[SRC_PIN_FIRST +: NUM_PINS]          = st.pin_ok;
      mx.src_vec[SRC_DAC_FIRST +: NUM_DAC]           = dac_pwm_req;
      mx.src_vec[SRC_MAIN_VIRT_FIRST +: NUM_VIRT]    = st.mv_ok;
      mx.src_vec[SRC_SEC_VIRT_FIRST +: NUM_VIRT]     = virtual_remap_pin;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Split every register into its two selector fields.
   always_comb begin
      for (int f = 0; f < NUM_FIELDS; f++) begin
         mx.sel[f] = st.sel[f / 2][(f % 2) * SEL_W +: SEL_W];
      end
   end

   source_mux u_mux (
      .m (mx.mux)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Next-state logic.
   always_comb begin
      next_st = st;

      // Pin sources pass three flops; a level is taken only once the last two
      // agree, which filters a single-cycle glitch at the cost of latency.
      next_st.pin_s1 = remappable_source;
      next_st.pin_s2 = st.pin_s1;
      next_st.pin_s3 = st.pin_s2;
      next_st.pin_ok = (~(st.pin_s2 ^ st.pin_s3) & st.pin_s3)
                     | ((st.pin_s2 ^ st.pin_s3) & st.pin_ok);

      // Main core virtual outputs cross from the other core and get the very
      // same treatment, so they time exactly like a physical pin.
      next_st.mv_s1 = main_virtual_outputs;
      next_st.mv_s2 = st.mv_s1;
      next_st.mv_s3 = st.mv_s2;
      next_st.mv_ok = (~(st.mv_s2 ^ st.mv_s3) & st.mv_s3)
                    | ((st.mv_s2 ^ st.mv_s3) & st.mv_ok);

      // Secondary virtual pins are handed to the main core side unchanged.
      next_st.to_main = virtual_remap_pin;

      // Register writes. The lock bit itself stays writable at all times.
      if (reg_wr) begin
         if (reg_addr == LOCK_OFFSET) begin
            next_st.lock = reg_wdata[LOCK_BIT];
         end else if (sel_hit && !st.lock) begin
            next_st.sel[sel_idx] = (st.sel[sel_idx] & ~field_mask(sel_idx))
                                 | (reg_wdata & field_mask(sel_idx));
         end
      end

      // Register reads answer one cycle later and only then.
      next_st.rdata = '0;
      if (reg_rd) begin
         if (reg_addr == LOCK_OFFSET) begin
            next_st.rdata[LOCK_BIT] = st.lock;
         end else if (sel_hit) begin
            next_st.rdata = st.sel[sel_idx] & field_mask(sel_idx);
         end
      end

      // Routed inputs are registered so every output comes from a flop.
      next_st.periph = mx.routed;
      next_st.trig   = mx.routed[ADC_TRIG_FIELD];
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State register.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st        <= '0;
         st.lock   <= LOCK_RESET;
         st.sel    <= {NUM_SEL_REGS{SEL_RESET}};
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs.
   always_comb begin
      reg_rdata            = st.rdata;
      periph_in            = st.periph;
      converter_trigger_31 = st.trig;
      to_main_virtual      = st.to_main;
      remap_write_lock     = st.lock;
   end

endmodule : secondary_input_pin_select
`default_nettype wire

// *** include/pin_select_pkg.sv ***
// Constants and types shared by the secondary input pin-select block.
// Functional notes
// - Sources 170 to 175 follow the main core virtual outputs 0 to 5.
// - Selector values 1 to 13 pick internal signals of both cores, not pins.
// - Six secondary virtual signals 0 to 5 feed main-side sources 176 to 181.
// - Each input has its own 8-bit selector; two selectors share a 16-bit register.
// - Converter trigger 31 selector sits in the high byte beside logic cell D.
// - An output on one core mapped to a virtual pin drives the other core's input.
// - Main core virtual sources behave exactly like pin sources; secondary virtual sources 176 to 181 skip the pin sync flops.
// - No interlocks between selectors; any source may feed many inputs.
package pin_select_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Widths and counts.
   localparam int SEL_W        = 8;
   localparam int REG_W        = 16;
   localparam int NUM_SRC      = 256;
   localparam int NUM_SEL_REGS = 24;
   localparam int NUM_FIELDS   = 48;
   localparam int ADDR_W       = 5;
   localparam int PIN_COUNT    = 40;
   localparam int NUM_INTERNAL = 13;
   localparam int NUM_DAC      = 6;
   localparam int NUM_VIRT     = 6;

   ////////////////////////////////////////////////////////////////////////////////
   // Source numbering of the selector values.
   localparam int SRC_INTERNAL_FIRST  = 1;
   localparam int SRC_PIN_FIRST       = 32;
   localparam int SRC_DAC_FIRST       = 162;
   localparam int SRC_MAIN_VIRT_FIRST = 170;
   localparam int SRC_SEC_VIRT_FIRST  = 176;

   ////////////////////////////////////////////////////////////////////////////////
   // Register map, as word indices on the register port.
   localparam logic [ADDR_W-1:0] LOCK_OFFSET     = 5'h00;
   localparam logic [ADDR_W-1:0] SEL_BASE_OFFSET = 5'h01;
   localparam logic [ADDR_W-1:0] SEL_LAST_OFFSET = 5'h18;
   localparam int                LOCK_BIT        = 11;
   localparam logic              LOCK_RESET      = 1'b0;
   localparam logic [REG_W-1:0]  SEL_RESET       = 16'h0000;

   // Which byte of each selector register holds a field, one bit per register.
   localparam logic [NUM_SEL_REGS-1:0] LO_USED = 24'hde7ffa;
   localparam logic [NUM_SEL_REGS-1:0] HI_USED = 24'hedffff;

   // Field index of converter trigger 31: high byte of the last register.
   localparam int ADC_TRIG_FIELD = 47;
   localparam int LOGIC_D_FIELD  = 46;

endpackage : pin_select_pkg

// *** include/sel_mux_if.sv ***
// Carrier between the register side and the source multiplexer.
`timescale 1ns/1ps
`default_nettype none
interface sel_mux_if;
   import pin_select_pkg::*;
   logic [NUM_SRC-1:0]                src_vec;
   logic [NUM_FIELDS-1:0][SEL_W-1:0]  sel;
   logic [NUM_FIELDS-1:0]             routed;
   modport regs (output src_vec, output sel, input routed);
   modport mux  (input src_vec, input sel, output routed);
endinterface : sel_mux_if
`default_nettype wire

// *** src/source_mux.sv ***
// Per-input source multiplexer: each field picks one bit of the source vector.
`timescale 1ns/1ps
`default_nettype none
module source_mux
   import pin_select_pkg::*;
(
   // Selector and source carrier.
   sel_mux_if.mux m
);

   ////////////////////////////////////////////////////////////////////////////////
   // An 8-bit selector must cover the whole source space, no more and no less.
   generate
      if (NUM_SRC != (1 << SEL_W)) begin : g_bad_width
         $error("source space does not match selector width");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // Every input decodes its own selector; nothing stops two inputs from
   // naming the same source. Reserved codes land on zero bits of the vector.
   genvar f;
   generate
      for (f = 0; f < NUM_FIELDS; f++) begin : g_field
         assign m.routed[f] = m.src_vec[m.sel[f]];
      end
   endgenerate

endmodule : source_mux
`default_nettype wire

// *** verif/pin_select_monitor.sv ***
// Port checks for the secondary input pin-select block.
`timescale 1ns/1ps
`default_nettype none
module pin_select_monitor
   import pin_select_pkg::*;
(
   // Clock, reset and register port.
   input wire logic                  mclk,
   input wire logic                  rst,
   input wire logic [ADDR_W-1:0]     reg_addr,
   input wire logic [REG_W-1:0]      reg_wdata,
   input wire logic                  reg_wr,
   input wire logic                  reg_rd,
   input wire logic [REG_W-1:0]      reg_rdata,
   // Routing.
   input wire logic [NUM_VIRT-1:0]   virtual_remap_pin,
   input wire logic [NUM_FIELDS-1:0] periph_in,
   input wire logic                  converter_trigger_31,
   input wire logic [NUM_VIRT-1:0]   to_main_virtual,
   input wire logic                  remap_write_lock
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   // Bytes without a field must read back as zero, so the mask follows the field map.
   function automatic logic [REG_W-1:0] fmask(input logic [ADDR_W-1:0] a);
      fmask = {{8{HI_USED[a-5'h01]}}, {8{LO_USED[a-5'h01]}}};
   endfunction : fmask
   // An unlocked selector write.
   wire logic sel_wr = reg_wr && !remap_write_lock && reg_addr >= SEL_BASE_OFFSET
                       && reg_addr <= SEL_LAST_OFFSET;
   sequence s_wr_rd;
      sel_wr ##1 (reg_rd && reg_addr == $past(reg_addr));
   endsequence
   property p_sel_rb;
      s_wr_rd |=> reg_rdata == ($past(reg_wdata, 2) & fmask($past(reg_addr, 2)));
   endproperty
   a_sel_rb: assert property (p_sel_rb) else $error("selector readback wrong");
   property p_rdata_idle;
      !reg_rd |=> reg_rdata == 16'h0000;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
   property p_unmapped;
      reg_rd && reg_addr > SEL_LAST_OFFSET |=> reg_rdata == 16'h0000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_lock_set;
      reg_wr && reg_addr == LOCK_OFFSET |=> remap_write_lock == $past(reg_wdata[LOCK_BIT]);
   endproperty
   a_lock_set: assert property (p_lock_set) else $error("lock write lost");
   property p_lock_hold;
      !(reg_wr && reg_addr == LOCK_OFFSET) |=> $stable(remap_write_lock);
   endproperty
   a_lock_hold: assert property (p_lock_hold) else $error("lock moved by itself");
   property p_lock_rd;
      reg_rd && reg_addr == LOCK_OFFSET |=>
         reg_rdata == ({15'h0000, $past(remap_write_lock)} << LOCK_BIT);
   endproperty
   a_lock_rd: assert property (p_lock_rd) else $error("lock readback wrong");
   property p_virt_fwd;
      1'b1 |=> to_main_virtual == $past(virtual_remap_pin);
   endproperty
   a_virt_fwd: assert property (p_virt_fwd) else $error("virtual forward wrong");
   property p_trig;
      $changed(periph_in[ADC_TRIG_FIELD]) |-> ##[0:1]
         (converter_trigger_31 == periph_in[ADC_TRIG_FIELD]);
   endproperty
   a_trig: assert property (p_trig) else $error("trigger copy wrong");
endmodule : pin_select_monitor
bind secondary_input_pin_select pin_select_monitor u_pin_select_monitor (.mclk, .rst,
   .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .virtual_remap_pin, .periph_in,
   .converter_trigger_31, .to_main_virtual, .remap_write_lock);
`default_nettype wire

// *** verif/main_core_model.sv ***
// Behavioural main core side of the virtual pin links.
`timescale 1ns/1ps
`default_nettype none
module main_core_model
   import pin_select_pkg::*;
(
   // Levels the bench asks the main core to put out.
   input  wire logic [NUM_VIRT-1:0] drive,
   // Virtual links across the core boundary.
   output var  logic [NUM_VIRT-1:0] main_virtual_outputs,
   input  wire logic [NUM_VIRT-1:0] to_main_virtual,
   output var  logic [NUM_VIRT-1:0] seen
);
   // The main core has its own clock, so its outputs move off our edges.
   initial main_virtual_outputs = 6'h00;
   always @(drive) main_virtual_outputs <= #7 drive;
   // The main input stage follows whatever the secondary side sends.
   assign seen = to_main_virtual;
endmodule : main_core_model
`default_nettype wire

// *** verif/tb_secondary_input_pin_select.sv ***
// Self-checking bench for the secondary input pin-select block.
`timescale 1ns/1ps
`default_nettype none
module tb_secondary_input_pin_select
   import pin_select_pkg::*;
;
   logic                    mclk = 1'h0, rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, trig, lock;
   logic [ADDR_W-1:0]       reg_addr = 5'h00;
   logic [REG_W-1:0]        reg_wdata = 16'h0000, reg_rdata, q;
   logic [PIN_COUNT-1:0]    pins = 40'h0;
   logic [NUM_INTERNAL-1:0] intl = 13'h0;
   logic [NUM_DAC-1:0]      dac = 6'h00;
   logic [NUM_VIRT-1:0]     mv_drive = 6'h00, sec_virt = 6'h00, mvo, tmv, seen;
   logic [NUM_FIELDS-1:0]   periph_in;
   int                      error_cnt = 0, checks_done = 0, cycles = 0;
   int codes[14] = '{0, 1, 13, 14, 32, 71, 162, 167, 168, 170, 175, 176, 181, 200};
   secondary_input_pin_select #(.NUM_PINS(PIN_COUNT)) u_secondary_input_pin_select (
      .mclk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .remappable_source(pins), .internal_src(intl), .dac_pwm_req(dac),
      .main_virtual_outputs(mvo), .virtual_remap_pin(sec_virt), .periph_in,
      .converter_trigger_31(trig), .to_main_virtual(tmv), .remap_write_lock(lock));
   main_core_model u_main_core_model (.drive(mv_drive), .main_virtual_outputs(mvo),
      .to_main_virtual(tmv), .seen);
   ////////////////////////////////////////////////////////////////////////////////
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : finish_test
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // One bus cycle; q holds the read data of the cycle that just ended.
   task automatic bus(input logic w, r, input logic [ADDR_W-1:0] a, input logic [15:0] d);
      reg_wr <= w;
      reg_rd <= r;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      q = reg_rdata;
   endtask : bus
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
      bus(1'h1, 1'h0, a, d);
   endtask : wr
   task automatic idle(input int n);
      repeat (n) bus(1'h0, 1'h0, 5'h00, 16'h0000);
   endtask : idle
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [15:0] e);
      bus(1'h0, 1'h1, a, 16'h0000);
      idle(1);
      chk("reg_rdata", e, q);
   endtask : rd
   // Drives one source; a code without a source drives every source, which must not leak.
   task automatic set_src(input int c, input logic v);
      if (c >= 1 && c <= 13) intl[c-1] <= v;
      else if (c >= 32 && c <= 71) pins[c-32] <= v;
      else if (c >= 162 && c <= 167) dac[c-162] <= v;
      else if (c >= 170 && c <= 175) mv_drive[c-170] <= v;
      else if (c >= 176 && c <= 181) sec_virt[c-176] <= v;
      else {intl, pins, dac, mv_drive, sec_virt} <= {71{v}};
   endtask : set_src
   ////////////////////////////////////////////////////////////////////////////////
   // Clock and hang guard; a few hundred cycles are expected, so the ceiling is generous.
   initial forever #25 mclk = ~mclk;
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         error_cnt++;
         finish_test();
      end
   end
   // Main sequence.
   initial begin
      logic e;
      repeat (20) @(posedge mclk);
      rst <= 1'h0;
      for (int a = 0; a < 32; a++) rd(5'(a), 16'h0000);
      $display("test reset_values done");
      for (int a = 1; a <= 24; a++) begin
         wr(5'(a), 16'ha55a ^ 16'(a));
         rd(5'(a), (16'ha55a ^ 16'(a)) & {{8{HI_USED[a-1]}}, {8{LO_USED[a-1]}}});
      end
      wr(5'h1f, 16'hffff);
      rd(5'h1f, 16'h0000);
      wr(LOCK_OFFSET, 16'hffff);
      rd(LOCK_OFFSET, 16'h0800);
      chk("remap_write_lock", 16'h0001, {15'h0, lock});
      wr(LOCK_OFFSET, 16'h0000);
      $display("test register_access done");
      foreach (codes[i]) begin
         e = codes[i] inside {[1:13], [32:71], [162:167], [170:181]};
         wr(5'h0e, {2{8'(codes[i])}});
         set_src(codes[i], 1'h1);
         idle(7);
         chk("periph_in 27:26", {14'h0, e, e}, {14'h0, periph_in[27:26]});
         set_src(codes[i], 1'h0);
         idle(7);
         chk("periph_in 27:26", 16'h0000, {14'h0, periph_in[27:26]});
      end
      $display("test source_routing done");
      sec_virt <= 6'h2a;
      idle(2);
      chk("to_main_virtual", 16'h002a, {10'h0, seen});
      sec_virt <= 6'h00;
      wr(SEL_LAST_OFFSET, 16'h0100);
      intl[0] <= 1'h1;
      idle(7);
      chk("converter_trigger_31", 16'h0001, {15'h0, trig});
      chk("logic cell d", 16'h0000, {15'h0, periph_in[LOGIC_D_FIELD]});
      $display("test virtual_and_trigger done");
      wr(5'h0e, 16'h2120);
      wr(LOCK_OFFSET, 16'h0800);
      wr(5'h0e, 16'h0101);
      rd(5'h0e, 16'h2120);
      pins[0] <= 1'h1;
      idle(7);
      chk("periph_in 27:26", 16'h0001, {14'h0, periph_in[27:26]});
      wr(LOCK_OFFSET, 16'h0000);
      wr(5'h0e, 16'h0101);
      rd(5'h0e, 16'h0101);
      idle(7);
      chk("periph_in 27:26", 16'h0003, {14'h0, periph_in[27:26]});
      $display("test write_lock done");
      finish_test();
   end
endmodule : tb_secondary_input_pin_select
`default_nettype wire
